// ===== prd_pkg.sv
// shared constants of the six-channel predriver serial control block
// assumes one 50 MHz clock and a synchronous active-high reset
package prd_pkg;
  localparam int CHANNELS = 6;
  localparam int CMD_FIFO_DEPTH = 8;
  localparam int CLK_PERIOD_NS = 20;
  // three-stage pin synchroniser, change taken when stages 2 and 3 agree
  localparam int SYNC_STAGES = 3;
  // bit positions inside the synchronised pin bundle
  localparam int PIN_SCLK = 0;
  localparam int PIN_CS_N = 1;
  localparam int PIN_SDI = 2;
  localparam int PIN_REF_SEL = 3;
  localparam int PIN_PAR_LSB = 4;
  localparam int PIN_SHORT_INT_LSB = PIN_PAR_LSB + CHANNELS;
  localparam int PIN_SHORT_EXT_LSB = PIN_SHORT_INT_LSB + CHANNELS;
  localparam int PIN_OPEN_INT_LSB = PIN_SHORT_EXT_LSB + CHANNELS;
  localparam int PIN_OPEN_EXT_LSB = PIN_OPEN_INT_LSB + CHANNELS;
  localparam int PIN_WIDTH = PIN_OPEN_EXT_LSB + CHANNELS;
  // reset values
  localparam logic [CHANNELS-1:0] CTRL_RESET = 6'h00;
  // only chip select idles high, so no false frame edge follows reset
  localparam logic [PIN_WIDTH-1:0] PIN_RESET = 28'h0000002;
  localparam logic SDO_IDLE = 1'b0;
  // position of channel 0 in the shift register: last bit shifted in
  localparam int CH0_BIT = 0;
endpackage

// ===== prd_fifo_if.sv
// carrier between the serial front end and the command queue
// assumes both ends on the same clock
`timescale 1ns/1ps
interface prd_fifo_if #(
  parameter int WIDTH = 6
);
  logic push_valid;
  logic push_ready;
  logic [WIDTH-1:0] push_data;
  logic pop_valid;
  logic pop_ready;
  logic [WIDTH-1:0] pop_data;
  modport store (
    input push_valid,
    output push_ready,
    input push_data,
    output pop_valid,
    input pop_ready,
    output pop_data
  );
  modport user (
    output push_valid,
    input push_ready,
    output push_data,
    input pop_valid,
    output pop_ready,
    input pop_data
  );
endinterface

// ===== prd_cmd_fifo.sv
// synchronous command queue with valid/ready on both sides
// assumes the user drives push and pop from the same clock
`timescale 1ns/1ps
module prd_cmd_fifo #(
  parameter int WIDTH = 6,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic reset,
  prd_fifo_if.store q
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0] wr_ptr_ff;
  logic [AW-1:0] rd_ptr_ff;
  logic [AW:0] count_ff;
  logic do_push;
  logic do_pop;

  function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
    ptr_inc = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  assign q.push_ready = (count_ff != (AW+1)'(DEPTH));
  assign q.pop_valid = (count_ff != '0);
  assign q.pop_data = mem_ff[rd_ptr_ff];
  assign do_push = q.push_valid && q.push_ready;
  assign do_pop = q.pop_valid && q.pop_ready;

  always_ff @(posedge clk) begin
    if (do_push) begin
      mem_ff[wr_ptr_ff] <= q.push_data;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
    end else begin
      if (do_push) begin
        wr_ptr_ff <= ptr_inc(wr_ptr_ff);
      end
      if (do_pop) begin
        rd_ptr_ff <= ptr_inc(rd_ptr_ff);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      count_ff <= '0;
    end else if (do_push && !do_pop) begin
      count_ff <= count_ff + 1'b1;
    end else if (do_pop && !do_push) begin
      count_ff <= count_ff - 1'b1;
    end
  end

  AST_FIFO_NO_OVERFLOW: assert property (@(posedge clk) disable iff (reset)
    count_ff <= (AW+1)'(DEPTH)) else $error("queue count above depth");
  AST_FIFO_FULL_BLOCKS: assert property (@(posedge clk) disable iff (reset)
    (count_ff == (AW+1)'(DEPTH)) && !do_pop |=> count_ff == (AW+1)'(DEPTH))
    else $error("full queue changed without a pop");
endmodule

// ===== prd_serial_ctrl.sv
// six-channel predriver: serial command/fault port, parallel inputs, gate drive
// assumes every pin input is asynchronous to clk and the pin bundle is sampled by clk
`timescale 1ns/1ps
// Behaviour
// [R01] shift in and out on serial clock falling
// [R02] command one turns gate on, zero off
// [R03] serial output carries latched fault bits
// [R04] after faults, forward serial input for chaining
// [R05] serial output released while chip select high
// [R06] parallel inputs command gates without serial port
// [R07] reference select chooses internal or external
// [R08] chip select fall: snapshot faults, enable, refresh
// [R09] chip select rise: commands to output control
// [R10] fault registers update only while deselected
// [R11] gate on if serial or parallel asks
// [R12] six-bit shift register, channel 0 last
module prd_serial_ctrl #(
  parameter int CHANNELS = prd_pkg::CHANNELS,
  parameter int FIFO_DEPTH = prd_pkg::CMD_FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic serial_clk,
  input wire logic chip_select_n,
  input wire logic serial_in,
  output logic serial_out_o,
  output logic serial_out_oe,
  input wire logic [CHANNELS-1:0] parallel_channel_cmd,
  input wire logic fault_ref_select,
  input wire logic [CHANNELS-1:0] short_cmp_internal,
  input wire logic [CHANNELS-1:0] short_cmp_external,
  input wire logic [CHANNELS-1:0] open_cmp_internal,
  input wire logic [CHANNELS-1:0] open_cmp_external,
  input wire logic gate_update_allow,
  output logic frame_accept_ready,
  output logic [CHANNELS-1:0] gate_drive_out,
  output logic open_drain_fault_flag_o,
  output logic open_drain_fault_flag_oe
);
  localparam int PW = prd_pkg::PIN_WIDTH;
  logic [PW-1:0] pin_s1_ff;
  logic [PW-1:0] pin_s2_ff;
  logic [PW-1:0] pin_s3_ff;
  logic [PW-1:0] pin_ff;
  logic [PW-1:0] nxt_pin;
  logic sclk_prev_ff;
  logic cs_n_prev_ff;
  logic sclk_fall;
  logic cs_fall;
  logic cs_rise;
  logic cs_n;
  logic ref_sel;
  logic [CHANNELS-1:0] par_cmd;
  logic [CHANNELS-1:0] fault_now;
  logic [CHANNELS-1:0] fault_reg_ff;
  logic [CHANNELS-1:0] shift_ff;
  logic sdo_ff;
  logic sdo_en_ff;
  logic [CHANNELS-1:0] ctrl_ff;
  logic [CHANNELS-1:0] gate_ff;
  logic flag_ff;

  prd_fifo_if #(.WIDTH(CHANNELS)) cmd_q ();

  prd_cmd_fifo #(.WIDTH(CHANNELS), .DEPTH(FIFO_DEPTH)) u_cmd_fifo (
    .clk(clk),
    .reset(reset),
    .q(cmd_q.store)
  );

  // pins pass three stages; a change is taken once stages 2 and 3 agree
  always_comb begin
    nxt_pin = pin_ff;
    for (int i = 0; i < PW; i++) begin
      if (pin_s2_ff[i] == pin_s3_ff[i]) begin
        nxt_pin[i] = pin_s3_ff[i];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      pin_s1_ff <= prd_pkg::PIN_RESET;
      pin_s2_ff <= prd_pkg::PIN_RESET;
      pin_s3_ff <= prd_pkg::PIN_RESET;
      pin_ff <= prd_pkg::PIN_RESET;
    end else begin
      pin_s1_ff <= {open_cmp_external, open_cmp_internal, short_cmp_external,
                    short_cmp_internal, parallel_channel_cmd, fault_ref_select,
                    serial_in, chip_select_n, serial_clk};
      pin_s2_ff <= pin_s1_ff;
      pin_s3_ff <= pin_s2_ff;
      pin_ff <= nxt_pin;
    end
  end

  assign cs_n = pin_ff[prd_pkg::PIN_CS_N];
  assign ref_sel = pin_ff[prd_pkg::PIN_REF_SEL];
  assign par_cmd = pin_ff[prd_pkg::PIN_PAR_LSB +: CHANNELS];

  always_ff @(posedge clk) begin
    if (reset) begin
      sclk_prev_ff <= 1'b0;
      cs_n_prev_ff <= 1'b1;
    end else begin
      sclk_prev_ff <= pin_ff[prd_pkg::PIN_SCLK];
      cs_n_prev_ff <= cs_n;
    end
  end

  assign sclk_fall = sclk_prev_ff && !pin_ff[prd_pkg::PIN_SCLK] && !cs_n; // R01
  assign cs_fall = cs_n_prev_ff && !cs_n;
  assign cs_rise = !cs_n_prev_ff && cs_n;

  // shorted-load is judged while the channel is on, open-load while off
  always_comb begin
    for (int c = 0; c < CHANNELS; c++) begin
      if (gate_ff[c]) begin
        fault_now[c] = ref_sel ? pin_ff[prd_pkg::PIN_SHORT_EXT_LSB + c] // R07
                               : pin_ff[prd_pkg::PIN_SHORT_INT_LSB + c];
      end else begin
        fault_now[c] = ref_sel ? pin_ff[prd_pkg::PIN_OPEN_EXT_LSB + c] // R07
                               : pin_ff[prd_pkg::PIN_OPEN_INT_LSB + c];
      end
    end
  end

  // faults accumulate while deselected, restart from live state at frame start
  always_ff @(posedge clk) begin
    if (reset) begin
      fault_reg_ff <= '0;
    end else if (cs_fall) begin
      fault_reg_ff <= fault_now; // R08
    end else if (cs_n) begin
      fault_reg_ff <= fault_reg_ff | fault_now; // R10
    end
  end

  // flag follows the fault registers, so the frame start refreshes it
  always_ff @(posedge clk) begin
    if (reset) begin
      flag_ff <= 1'b0;
    end else if (cs_fall) begin
      flag_ff <= |fault_now; // R08
    end else begin
      flag_ff <= |(fault_reg_ff | fault_now);
    end
  end

  assign open_drain_fault_flag_o = 1'b0;
  assign open_drain_fault_flag_oe = flag_ff;

  // one shift register serves command input, fault output and pass-through
  always_ff @(posedge clk) begin
    if (reset) begin
      shift_ff <= prd_pkg::CTRL_RESET;
      sdo_ff <= prd_pkg::SDO_IDLE;
    end else if (cs_fall) begin
      shift_ff <= fault_reg_ff | fault_now; // R03 R08
      sdo_ff <= fault_reg_ff[CHANNELS-1] | fault_now[CHANNELS-1];
    end else if (sclk_fall) begin
      shift_ff <= {shift_ff[CHANNELS-2:0], pin_ff[prd_pkg::PIN_SDI]}; // R01 R12
      sdo_ff <= shift_ff[CHANNELS-2]; // R04
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      sdo_en_ff <= 1'b0;
    end else begin
      sdo_en_ff <= !cs_n; // R05 R08
    end
  end

  assign serial_out_o = sdo_ff;
  assign serial_out_oe = sdo_en_ff;

  // a frame that finds the queue full is dropped; the host sees frame_accept_ready low
  assign cmd_q.push_valid = cs_rise; // R09
  assign cmd_q.push_data = shift_ff;
  assign cmd_q.pop_ready = gate_update_allow;
  assign frame_accept_ready = cmd_q.push_ready;

  always_ff @(posedge clk) begin
    if (reset) begin
      ctrl_ff <= prd_pkg::CTRL_RESET;
    end else if (cmd_q.pop_valid && gate_update_allow) begin
      ctrl_ff <= cmd_q.pop_data; // R09
    end
  end

  // synchronised, not truly unclocked: costs a few cycles of latency
  always_ff @(posedge clk) begin
    if (reset) begin
      gate_ff <= prd_pkg::CTRL_RESET;
    end else begin
      gate_ff <= ctrl_ff | par_cmd; // R02 R06 R11
    end
  end

  assign gate_drive_out = gate_ff;

  sequence s_frame_open;
    cs_fall;
  endsequence
  sequence s_frame_close;
    cs_rise && cmd_q.push_ready;
  endsequence

  AST_SDO_RELEASED: assert property (@(posedge clk) disable iff (reset)
    cs_n |=> !serial_out_oe) else $error("serial output driven while deselected"); // R05
  AST_SDO_ENABLED: assert property (@(posedge clk) disable iff (reset)
    s_frame_open |=> serial_out_oe) else $error("serial output not enabled"); // R08
  AST_SNAPSHOT: assert property (@(posedge clk) disable iff (reset)
    s_frame_open |=> shift_ff == $past(fault_reg_ff | fault_now))
    else $error("fault snapshot not loaded"); // R03
  AST_SHIFT_IN: assert property (@(posedge clk) disable iff (reset)
    sclk_fall && !cs_fall |=> shift_ff[prd_pkg::CH0_BIT] == $past(pin_ff[prd_pkg::PIN_SDI]))
    else $error("serial input not shifted"); // R01
  AST_PASS_THROUGH: assert property (@(posedge clk) disable iff (reset)
    sclk_fall && !cs_fall |=> sdo_ff == $past(shift_ff[CHANNELS-2]))
    else $error("pass-through bit wrong"); // R04
  AST_FROZEN: assert property (@(posedge clk) disable iff (reset)
    !cs_n && !cs_fall |=> (fault_reg_ff == $past(fault_reg_ff)))
    else $error("fault registers moved during frame"); // R10
  AST_CMD_APPLY: assert property (@(posedge clk) disable iff (reset)
    (s_frame_close and (!cmd_q.pop_valid && gate_update_allow))
      |=> ##1 ctrl_ff == $past(shift_ff, 2)) else $error("command not applied"); // R09
  AST_GATE_OR: assert property (@(posedge clk) disable iff (reset)
    1'b1 |=> gate_ff == ($past(ctrl_ff) | $past(par_cmd)))
    else $error("gate not the OR of both commands"); // R11
  AST_PAR_ON: assert property (@(posedge clk) disable iff (reset)
    par_cmd[0] [*2] |-> gate_ff[0]) else $error("parallel command ignored"); // R06
  AST_REF_SEL: assert property (@(posedge clk) disable iff (reset)
    ref_sel && gate_ff[0] |-> fault_now[0] == pin_ff[prd_pkg::PIN_SHORT_EXT_LSB])
    else $error("external reference not used"); // R07
endmodule

// ===== prd_host_model.sv
// host side model: frames the serial port and collects returned bits
// assumes the device samples its pins with clk, so each level is held at least 4 clk
`timescale 1ns/1ps
module prd_host_model (
  input wire logic clk,
  output logic serial_clk,
  output logic chip_select_n,
  output logic serial_in,
  input wire logic serial_out_o,
  input wire logic serial_out_oe
);
  logic last_ff;
  wire logic sdo;
  // released line toggles, so a stale bit never reads as valid
  assign sdo = serial_out_oe ? serial_out_o : ~last_ff;
  initial begin
    serial_clk = 1'b0;
    chip_select_n = 1'b1;
    serial_in = 1'b0;
    last_ff = 1'b0;
  end
  always @(posedge clk) last_ff <= sdo;
  task automatic xfer(input logic [11:0] d, input int n, output logic [11:0] q,
    output logic oe_seen);
    q = 12'h000;
    oe_seen = 1'b1;
    chip_select_n = 1'b0;
    repeat (8) @(negedge clk);
    for (int k = n - 1; k >= 0; k--) begin
      serial_in = d[k];
      repeat (4) @(negedge clk);
      q[k] = sdo;
      oe_seen = oe_seen & serial_out_oe;
      serial_clk = 1'b1;
      repeat (4) @(negedge clk);
      serial_clk = 1'b0;
      repeat (4) @(negedge clk);
    end
    chip_select_n = 1'b1;
    serial_in = 1'b0;
    repeat (8) @(negedge clk);
  endtask
endmodule

// ===== testbench.sv
// self-checking bench of the predriver serial control block
// assumes the host model owns the serial pins; bench drives the rest
`timescale 1ns/1ps
module testbench;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [5:0] par = 6'h00;
  logic ref_sel = 1'b0;
  logic [5:0] si = 6'h00, se = 6'h00, oi = 6'h00, oe = 6'h00;
  logic allow = 1'b1;
  wire logic sclk, cs_n, sdi, sdo, sdo_oe, ready, flag_o, flag_oe;
  wire logic [5:0] gate;
  logic [11:0] q;
  logic ok;
  int err_total = 0, n_checks = 0, cyc = 0;
  // columns: ref, short int, open int, short ext, open ext, read, flag
  logic [5:0] tf [5][7] = '{
    '{6'h01, 6'h05, 6'h02, 6'h00, 6'h10, 6'h10, 6'h01},
    '{6'h00, 6'h05, 6'h02, 6'h00, 6'h10, 6'h17, 6'h01},
    '{6'h00, 6'h05, 6'h02, 6'h00, 6'h10, 6'h07, 6'h01},
    '{6'h00, 6'h00, 6'h00, 6'h00, 6'h00, 6'h07, 6'h00},
    '{6'h00, 6'h00, 6'h00, 6'h00, 6'h00, 6'h00, 6'h00}};
  always #10 clk = ~clk;
  prd_host_model i_host (.clk(clk), .serial_clk(sclk), .chip_select_n(cs_n),
    .serial_in(sdi), .serial_out_o(sdo), .serial_out_oe(sdo_oe));
  prd_serial_ctrl i_dut (.clk(clk), .reset(reset), .serial_clk(sclk), .chip_select_n(cs_n),
    .serial_in(sdi), .serial_out_o(sdo), .serial_out_oe(sdo_oe),
    .parallel_channel_cmd(par), .fault_ref_select(ref_sel), .short_cmp_internal(si),
    .short_cmp_external(se), .open_cmp_internal(oi), .open_cmp_external(oe),
    .gate_update_allow(allow), .frame_accept_ready(ready), .gate_drive_out(gate),
    .open_drain_fault_flag_o(flag_o), .open_drain_fault_flag_oe(flag_oe));
  task chk(input logic [11:0] a, input logic [11:0] e);
    n_checks++;
    if (a !== e) begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, a, e);
    end
  endtask
  task results();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task t_reset();
    chk({gate, sdo_oe, flag_oe, flag_o, ready}, {6'h00, 4'b0001});
    $display("done reset");
  endtask
  task t_serial();
    i_host.xfer(12'h025, 6, q, ok);
    repeat (4) @(negedge clk);
    chk(q, 12'h000);
    chk({ok, sdo_oe}, 2'b10);
    chk(gate, 6'h25);
    $display("done serial");
  endtask
  task t_parallel();
    par = 6'h13;
    repeat (8) @(negedge clk);
    chk(gate, 6'h37);
    par = 6'h00;
    repeat (8) @(negedge clk);
    chk(gate, 6'h25);
    $display("done parallel");
  endtask
  task t_chain();
    i_host.xfer({6'h3c, 6'h25}, 12, q, ok);
    repeat (4) @(negedge clk);
    chk(q, 12'h03c);
    chk(gate, 6'h25);
    $display("done chain");
  endtask
  task t_faults();
    for (int i = 0; i < 5; i++) begin
      ref_sel = tf[i][0][0];
      si = tf[i][1];
      oi = tf[i][2];
      se = tf[i][3];
      oe = tf[i][4];
      repeat (8) @(negedge clk);
      i_host.xfer(12'h025, 6, q, ok);
      chk(q, {6'h00, tf[i][5]});
      chk(flag_oe, tf[i][6][0]);
    end
    $display("done faults");
  endtask
  task t_queue();
    allow = 1'b0;
    for (int i = 1; i <= 9; i++) begin
      i_host.xfer({6'h00, 6'(i)}, 6, q, ok);
      if (i == 8)
        chk(ready, 1'b0);
    end
    chk(gate, 6'h25);
    allow = 1'b1;
    repeat (40) @(negedge clk);
    chk({ready, gate}, {1'b1, 6'h08});
    $display("done queue");
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 6000) begin
      err_total++;
      results();
    end
  end
  initial begin
    repeat (5) @(negedge clk);
    reset = 1'b0;
    repeat (4) @(negedge clk);
    t_reset();
    t_serial();
    t_parallel();
    t_chain();
    t_faults();
    t_queue();
    results();
  end
endmodule
